// ==== hw/lhi_panel_end.sv ====
// Function
// - Straps select 3-wire, 4-wire, 8080, 6800
// - Serial writes only; parallel reads and writes
// - Transfers accepted only with chip select low
// - Select high means display_ram, low means command
// - Host ties select low in 3-wire mode
// - 6800 read/write line: high read, low write
// - 8080 write strobe falling edge latches write
// - 8080 read strobe falling edge drives read
// - Parallel read: select picks RAM or status
// - Display reads pipelined; first read is dummy
// - Serial: D7 data, D6 clock, rest high
// - 4-wire shifts MSB first on rising clock
// - 4-wire samples select on eighth clock
// - 3-wire word is flag plus eight bits
// - 3-wire flag one RAM, zero command
// - Power-on resets all; reset pin resets all but the pin synchronisers
// - Host holds reset pin low 10 us
// - Internal oscillator after reset; external by command
`timescale 1ns/1ps
module lhi_panel_end
	import lhi_pkg::*;
(
	input  wire logic       i_lclk,
	input  wire logic       i_reset_n,
	lhi_bus_if.panel        bus,
	input  wire logic [7:0] i_ram_rdata,
	input  wire logic [7:0] i_status,
	input  wire logic       i_ext_clk_cmd,
	output logic            o_wr_stb,
	output logic            o_wr_is_data,
	output logic [7:0]      o_wr_byte,
	output logic            o_ram_rd_stb,
	output logic [1:0]      o_mode,
	output logic            o_ext_clk_sel
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	localparam int PIN_W = 15;

	logic [PIN_W-1:0] pin_meta_q;
	logic [PIN_W-1:0] pin_sync_q;
	wire  [PIN_W-1:0] pins_raw;

	assign pins_raw = {bus.res_n, bus.protocol_strap_a, bus.protocol_strap_b, bus.cs_n,
	                   bus.dc, bus.rw_wr_n, bus.e_rd_n, bus.d};

	// Only the second stage is read; the first may be metastable
	always_ff @(posedge i_lclk) begin
		if (!i_reset_n) begin
			pin_meta_q <= '1;
			pin_sync_q <= '1;
		end else begin
			pin_meta_q <= pins_raw;
			pin_sync_q <= pin_meta_q;
		end
	end

	wire       res_s;
	wire       strap_a_s;
	wire       strap_b_s;
	wire       cs_n_s;
	wire       dc_s;
	wire       rw_wr_s;
	wire       e_rd_s;
	wire [7:0] d_s;

	assign {res_s, strap_a_s, strap_b_s, cs_n_s, dc_s, rw_wr_s, e_rd_s, d_s} = pin_sync_q;

	// ****************************************************************
	// Reset and mode
	// ****************************************************************
	wire rst;
	assign rst = !i_reset_n || !res_s;

	logic [1:0] mode_q;
	logic       ext_clk_q;

	always_ff @(posedge i_lclk) begin
		if (rst) begin
			mode_q    <= MODE_RST;
			ext_clk_q <= 1'b0;
		end else begin
			mode_q    <= {strap_a_s, strap_b_s};
			ext_clk_q <= i_ext_clk_cmd;
		end
	end

	wire is_par;
	wire is_i80;
	wire is_m68;
	wire is_spi4;
	wire selected;

	assign is_par   = mode_q[1];
	assign is_i80   = (mode_q == MODE_I80);
	assign is_m68   = (mode_q == MODE_M68);
	assign is_spi4  = (mode_q == MODE_SPI4);
	assign selected = !cs_n_s;

	// ****************************************************************
	// Parallel strobes
	// ****************************************************************
	logic rw_prev_q;
	logic e_prev_q;

	always_ff @(posedge i_lclk) begin
		if (rst) begin
			rw_prev_q <= 1'b1;
			e_prev_q  <= 1'b1;
		end else begin
			rw_prev_q <= rw_wr_s;
			e_prev_q  <= e_rd_s;
		end
	end

	wire i80_wr_fall;
	wire i80_rd_fall;
	wire m68_e_rise;
	wire par_wr;
	wire par_rd;
	wire rd_drive;

	assign i80_wr_fall = is_i80 && selected && rw_prev_q && !rw_wr_s;
	assign i80_rd_fall = is_i80 && selected && e_prev_q && !e_rd_s;
	assign m68_e_rise  = is_m68 && selected && !e_prev_q && e_rd_s;
	assign par_wr      = i80_wr_fall || (m68_e_rise && !rw_wr_s);
	assign par_rd      = i80_rd_fall || (m68_e_rise && rw_wr_s);
	// Bus stays driven only while the read strobe is held
	assign rd_drive    = selected && ((is_i80 && !e_rd_s) || (is_m68 && e_rd_s && rw_wr_s));

	// ****************************************************************
	// Serial shifter
	// ****************************************************************
	logic       sck_prev_q;
	logic [8:0] shift_q;
	logic [3:0] bits_q;

	wire       sck_s;
	wire       sda_s;
	wire       sck_rise;
	wire [8:0] shift_d;
	wire [3:0] last_bit;
	wire       ser_done;

	assign sck_s    = d_s[SCK_BIT];
	assign sda_s    = d_s[SDA_BIT];
	assign sck_rise = !is_par && selected && !sck_prev_q && sck_s;
	assign shift_d  = {shift_q[7:0], sda_s};
	assign last_bit = is_spi4 ? SPI4_LAST : SPI3_LAST;
	assign ser_done = sck_rise && (bits_q == last_bit);

	always_ff @(posedge i_lclk) begin
		if (rst) begin
			// High after reset, so a clock pin already high gives no false rise
			sck_prev_q <= 1'b1;
			shift_q    <= SHIFT_RST;
			bits_q     <= BITS_RST;
		end else begin
			sck_prev_q <= sck_s;
			if (!selected) begin
				shift_q <= SHIFT_RST;
				bits_q  <= BITS_RST;
			end else if (sck_rise) begin
				shift_q <= shift_d;
				bits_q  <= ser_done ? BITS_RST : bits_q + 4'h1;
			end
		end
	end

	// ****************************************************************
	// Write path to display_ram or command decoder
	// ****************************************************************
	wire       ser_is_data;
	wire       wr_is_data_d;
	wire [7:0] wr_byte_d;

	assign ser_is_data  = is_spi4 ? dc_s : shift_d[8];
	assign wr_is_data_d = is_par ? dc_s : ser_is_data;
	assign wr_byte_d    = is_par ? d_s : shift_d[7:0];

	logic       wr_stb_q;
	logic       wr_is_data_q;
	logic [7:0] wr_byte_q;

	always_ff @(posedge i_lclk) begin
		if (rst) begin
			wr_stb_q     <= 1'b0;
			wr_is_data_q <= 1'b0;
			wr_byte_q    <= BYTE_RST;
		end else begin
			wr_stb_q <= par_wr || ser_done;
			if (par_wr || ser_done) begin
				wr_is_data_q <= wr_is_data_d;
				wr_byte_q    <= wr_byte_d;
			end
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	// The pipeline latch means each display read returns the byte fetched
	// by the read before it, so the first one after a pointer move is stale.
	logic [7:0] rd_latch_q;
	logic [7:0] rd_out_q;
	logic       rd_oe_q;
	logic       ram_rd_stb_q;

	wire ram_rd;
	wire [7:0] rd_out_d;

	assign ram_rd   = par_rd && dc_s;
	assign rd_out_d = dc_s ? rd_latch_q : i_status;

	always_ff @(posedge i_lclk) begin
		if (rst) begin
			rd_latch_q   <= BYTE_RST;
			rd_out_q     <= BYTE_RST;
			rd_oe_q      <= 1'b0;
			ram_rd_stb_q <= 1'b0;
		end else begin
			rd_oe_q      <= rd_drive;
			ram_rd_stb_q <= ram_rd;
			if (par_rd) begin
				rd_out_q <= rd_out_d;
			end
			if (ram_rd) begin
				rd_latch_q <= i_ram_rdata;
			end
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign bus.p_d       = rd_out_q;
	assign bus.p_d_oe    = rd_oe_q;
	assign o_wr_stb      = wr_stb_q;
	assign o_wr_is_data  = wr_is_data_q;
	assign o_wr_byte     = wr_byte_q;
	assign o_ram_rd_stb  = ram_rd_stb_q;
	assign o_mode        = mode_q;
	assign o_ext_clk_sel = ext_clk_q;

endmodule

// ==== hw/lhi_pkg.sv ====
package lhi_pkg;

	// ****************************************************************
	// Protocol strap encodings {protocol_strap_a, protocol_strap_b}
	// ****************************************************************
	localparam logic [1:0] MODE_SPI3 = 2'h0;
	localparam logic [1:0] MODE_SPI4 = 2'h1;
	localparam logic [1:0] MODE_I80  = 2'h2;
	localparam logic [1:0] MODE_M68  = 2'h3;

	// ****************************************************************
	// Bus field positions and values
	// ****************************************************************
	localparam int         SDA_BIT      = 7;
	localparam int         SCK_BIT      = 6;
	localparam logic [7:0] SER_IDLE_BUS = 8'hbf;
	localparam logic [7:0] PAR_IDLE_BUS = 8'hff;
	localparam logic [5:0] SER_FILL     = 6'h3f;
	localparam logic [3:0] SPI4_LAST    = 4'h7;
	localparam logic [3:0] SPI3_LAST    = 4'h8;
	localparam logic [3:0] SPI4_BITS    = 4'h8;
	localparam logic [3:0] SPI3_BITS    = 4'h9;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] BYTE_RST  = 8'h00;
	localparam logic [8:0] SHIFT_RST = 9'h000;
	localparam logic [3:0] BITS_RST  = 4'h0;
	localparam logic [1:0] MODE_RST  = MODE_SPI3;

	// ****************************************************************
	// Timing of the controller end, in ns and us, rounded up to mclk cycles
	// ****************************************************************
	localparam int MCLK_PERIOD_NS = 8;
	localparam int SETUP_NS       = 96;
	localparam int STROBE_NS      = 240;
	localparam int HOLD_NS        = 240;
	localparam int SCK_HALF_NS    = 128;
	localparam int RESET_US       = 10;
	localparam int SETUP_CYC      = (SETUP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int STROBE_CYC     = (STROBE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int HOLD_CYC       = (HOLD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int SCK_HALF_CYC   = (SCK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int RESET_CYC      = (RESET_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int CNT_W          = 11;
	localparam logic [CNT_W-1:0] SETUP_LD  = CNT_W'(SETUP_CYC - 1);
	localparam logic [CNT_W-1:0] STROBE_LD = CNT_W'(STROBE_CYC - 1);
	localparam logic [CNT_W-1:0] HOLD_LD   = CNT_W'(HOLD_CYC - 1);
	localparam logic [CNT_W-1:0] SCK_LD    = CNT_W'(SCK_HALF_CYC - 1);
	localparam logic [CNT_W-1:0] RESET_LD  = CNT_W'(RESET_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO  = 11'h000;

	typedef enum logic [2:0] {
		H_IDLE,
		H_SETUP,
		H_STROBE,
		H_HOLD,
		H_SCK_LO,
		H_SCK_HI,
		H_RESET
	} lhi_hstate_t;

endpackage

// ==== hw/lhi_bus_if.sv ====
`timescale 1ns/1ps
interface lhi_bus_if;
	logic       res_n;
	logic       protocol_strap_a;
	logic       protocol_strap_b;
	logic       cs_n;
	logic       dc;
	logic       rw_wr_n;
	logic       e_rd_n;
	logic [7:0] h_d;
	logic       h_d_oe;
	logic [7:0] p_d;
	logic       p_d_oe;
	logic [7:0] d;

	// Resolved data bus; an undriven bus floats high
	assign d = p_d_oe ? p_d : (h_d_oe ? h_d : 8'hff);

	modport mcu (
		output res_n, protocol_strap_a, protocol_strap_b, cs_n, dc, rw_wr_n, e_rd_n, h_d, h_d_oe,
		input  d
	);
	modport panel (
		input  res_n, protocol_strap_a, protocol_strap_b, cs_n, dc, rw_wr_n, e_rd_n, d,
		output p_d, p_d_oe
	);
endinterface

// ==== hw/lhi_mcu_end.sv ====
`timescale 1ns/1ps
module lhi_mcu_end
	import lhi_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_reset_n,
	lhi_bus_if.mcu          bus,
	input  wire logic [1:0] i_mode,
	input  wire logic       i_req,
	input  wire logic       i_req_read,
	input  wire logic       i_req_dc,
	input  wire logic [7:0] i_req_byte,
	input  wire logic       i_res_req,
	output logic            o_busy,
	output logic            o_rd_valid,
	output logic [7:0]      o_rd_byte
);

	// ****************************************************************
	// Decode
	// ****************************************************************
	wire ser;
	wire m68;
	wire take;
	wire [7:0] idle_bus;

	assign ser      = !i_mode[1];
	assign m68      = (i_mode == MODE_M68);
	assign take     = i_req && !(ser && i_req_read);
	assign idle_bus = ser ? SER_IDLE_BUS : PAR_IDLE_BUS;

	logic [7:0] d_meta_q;
	logic [7:0] d_sync_q;

	always_ff @(posedge i_mclk) begin
		d_meta_q <= bus.d;
		d_sync_q <= d_meta_q;
	end

	// ****************************************************************
	// Transfer sequencer
	// ****************************************************************
	lhi_hstate_t      st_q;
	logic [CNT_W-1:0] cnt_q;
	logic [8:0]       sh_q;
	logic [3:0]       left_q;
	logic             rd_q;
	logic             res_n_q, sa_q, sb_q, cs_n_q, dc_q, rw_q, e_q, oe_q, busy_q, vld_q;
	logic [7:0]       d_q, rdb_q;

	wire cnt_end;
	assign cnt_end = (cnt_q == CNT_ZERO);

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			st_q <= H_IDLE; cnt_q <= CNT_ZERO; sh_q <= SHIFT_RST; left_q <= BITS_RST; rd_q <= 1'b0;
			res_n_q <= 1'b1; sa_q <= 1'b0; sb_q <= 1'b0; cs_n_q <= 1'b1; dc_q <= 1'b0;
			rw_q <= 1'b1; e_q <= 1'b1; oe_q <= 1'b0; d_q <= PAR_IDLE_BUS;
			busy_q <= 1'b0; vld_q <= 1'b0; rdb_q <= BYTE_RST;
		end else begin
			{sa_q, sb_q} <= i_mode;
			vld_q        <= 1'b0;
			cnt_q        <= cnt_end ? CNT_ZERO : cnt_q - 11'h001;
			unique case (st_q)
				H_IDLE: begin
					rw_q <= 1'b1;
					e_q  <= !m68;
					oe_q <= ser;
					d_q  <= idle_bus;
					if (i_mode == MODE_SPI3) dc_q <= 1'b0;
					if (i_res_req) begin
						res_n_q <= 1'b0;
						busy_q  <= 1'b1;
						cnt_q   <= RESET_LD;
						st_q    <= H_RESET;
					end else if (take) begin
						busy_q <= 1'b1;
						cs_n_q <= 1'b0;
						rd_q   <= i_req_read;
						if (ser) begin
							sh_q   <= {i_req_dc, i_req_byte};
							left_q <= (i_mode == MODE_SPI4) ? SPI4_BITS : SPI3_BITS;
							dc_q   <= (i_mode == MODE_SPI4) && i_req_dc;
							d_q    <= {(i_mode == MODE_SPI4) ? i_req_byte[7] : i_req_dc, 1'b0, SER_FILL};
							cnt_q  <= SCK_LD;
							st_q   <= H_SCK_LO;
						end else begin
							dc_q  <= i_req_dc;
							rw_q  <= !(m68 && !i_req_read);
							oe_q  <= !i_req_read;
							d_q   <= i_req_byte;
							cnt_q <= SETUP_LD;
							st_q  <= H_SETUP;
						end
					end
				end
				H_SETUP: if (cnt_end) begin
					if (m68) e_q <= 1'b1;
					else if (rd_q) e_q <= 1'b0;
					else rw_q <= 1'b0;
					cnt_q <= STROBE_LD;
					st_q  <= H_STROBE;
				end
				H_STROBE: if (cnt_end) begin
					if (rd_q) begin
						rdb_q <= d_sync_q;
						vld_q <= 1'b1;
					end
					e_q   <= !m68;
					rw_q  <= 1'b1;
					cnt_q <= HOLD_LD;
					st_q  <= H_HOLD;
				end
				H_SCK_LO: if (cnt_end) begin
					d_q[SCK_BIT] <= 1'b1;
					cnt_q        <= SCK_LD;
					st_q         <= H_SCK_HI;
				end
				H_SCK_HI: if (cnt_end) begin
					d_q[SCK_BIT] <= 1'b0;
					if (left_q == 4'h1) begin
						cnt_q <= HOLD_LD;
						st_q  <= H_HOLD;
					end else begin
						// 3-wire skips one shift after its flag so the byte then walks like 4-wire
						d_q[SDA_BIT] <= (left_q == 4'h9) ? sh_q[7] : sh_q[6];
						sh_q         <= (left_q == 4'h9) ? sh_q : {sh_q[7:0], 1'b0};
						left_q       <= left_q - 4'h1;
						cnt_q        <= SCK_LD;
						st_q         <= H_SCK_LO;
					end
				end
				H_HOLD: if (cnt_end) begin
					cs_n_q <= 1'b1;
					busy_q <= 1'b0;
					st_q   <= H_IDLE;
				end
				H_RESET: if (cnt_end) begin
					res_n_q <= 1'b1;
					busy_q  <= 1'b0;
					st_q    <= H_IDLE;
				end
			endcase
		end
	end

	assign bus.res_n            = res_n_q;
	assign bus.protocol_strap_a = sa_q;
	assign bus.protocol_strap_b = sb_q;
	assign bus.cs_n             = cs_n_q;
	assign bus.dc               = dc_q;
	assign bus.rw_wr_n          = rw_q;
	assign bus.e_rd_n           = e_q;
	assign bus.h_d              = d_q;
	assign bus.h_d_oe           = oe_q;
	assign o_busy               = busy_q;
	assign o_rd_valid           = vld_q;
	assign o_rd_byte            = rdb_q;

endmodule

// ==== bench/lhi_bus_chk.sv ====
`timescale 1ns/1ps
module lhi_bus_chk
	import lhi_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_lclk,
	input  wire logic       i_reset_n,
	input  wire logic       res_n,
	input  wire logic       protocol_strap_a,
	input  wire logic       protocol_strap_b,
	input  wire logic       cs_n,
	input  wire logic       dc,
	input  wire logic       rw_wr_n,
	input  wire logic       e_rd_n,
	input  wire logic [7:0] h_d,
	input  wire logic       h_d_oe,
	input  wire logic       p_d_oe
);
	wire [1:0] mode_w = {protocol_strap_a, protocol_strap_b};
	int        res_low_q;

	// ****************************************************************
	// Reset pulse width counter
	// ****************************************************************
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n || res_n)
			res_low_q <= 0;
		else
			res_low_q <= res_low_q + 1;
	end

	// ****************************************************************
	// Device side, link clock
	// ****************************************************************
	a_serial_no_drive: assert property (@(posedge i_lclk) disable iff (!i_reset_n)
		!protocol_strap_a |-> !p_d_oe) else $error("data bus driven in serial mode");
	a_deselect_no_drive: assert property (@(posedge i_lclk) disable iff (!i_reset_n)
		cs_n [*6] |-> !p_d_oe) else $error("data bus driven while deselected");
	a_i80_read_drive: assert property (@(posedge i_lclk) disable iff (!i_reset_n)
		mode_w == MODE_I80 && !cs_n && $fell(e_rd_n) |-> ##[1:5] p_d_oe) else $error("read strobe not answered");
	a_m68_read_drive: assert property (@(posedge i_lclk) disable iff (!i_reset_n)
		mode_w == MODE_M68 && rw_wr_n && !cs_n && $rose(e_rd_n) |-> ##[1:5] p_d_oe)
		else $error("enable read not answered");
	a_m68_write_quiet: assert property (@(posedge i_lclk) disable iff (!i_reset_n)
		(mode_w == MODE_M68 && !rw_wr_n) [*6] |-> !p_d_oe) else $error("bus driven during write");

	// ****************************************************************
	// Host side, main clock
	// ****************************************************************
	a_dc_low_3wire: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		mode_w == MODE_SPI3 |-> !dc) else $error("select not low in 3-wire mode");
	a_serial_fill_high: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		!protocol_strap_a && h_d_oe |-> h_d[5:0] == SER_FILL) else $error("serial fill bits not high");
	a_rw_before_e: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		mode_w == MODE_M68 && $stable(protocol_strap_b) && $rose(e_rd_n) |-> !cs_n && $stable(rw_wr_n))
		else $error("read/write line moved at enable");
	a_i80_wr_sel: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		mode_w == MODE_I80 && $stable(protocol_strap_b) && $fell(rw_wr_n) |-> !cs_n)
		else $error("write strobe without select");
	a_reset_width: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		$rose(res_n) |-> res_low_q >= RESET_CYC) else $error("reset pulse too short");

	c_i80_read: cover property (@(posedge i_lclk) disable iff (!i_reset_n) mode_w == MODE_I80 && p_d_oe);
	c_m68_read: cover property (@(posedge i_lclk) disable iff (!i_reset_n) mode_w == MODE_M68 && p_d_oe);
	c_host_reset: cover property (@(posedge i_mclk) disable iff (!i_reset_n) $rose(res_n));
endmodule

// ==== bench/lcd_host_interface_tb_top.sv ====
`timescale 1ns/1ps
module lcd_host_interface_tb_top
	import lhi_pkg::*;
;
	logic       mclk, lclk, rst_n, req, req_read, req_dc, res_req, ext_cmd;
	logic [1:0] mode, dev_mode;
	logic [7:0] req_byte, status, ram_ptr, rd_byte, wr_byte, latch, nrd;
	logic       busy, rd_valid, wr_stb, wr_is_data, ram_rd_stb, ext_sel;
	logic [8:0] wq[$], rq[$];
	int         errors, tests_run, cyc;

	lhi_bus_if lhi_bus_if_i ();
	lhi_mcu_end lhi_mcu_end_i (.i_mclk(mclk), .i_reset_n(rst_n), .bus(lhi_bus_if_i.mcu), .i_mode(mode),
		.i_req(req), .i_req_read(req_read), .i_req_dc(req_dc), .i_req_byte(req_byte), .i_res_req(res_req),
		.o_busy(busy), .o_rd_valid(rd_valid), .o_rd_byte(rd_byte));
	lhi_panel_end lhi_panel_end_i (.i_lclk(lclk), .i_reset_n(rst_n), .bus(lhi_bus_if_i.panel),
		.i_ram_rdata(ram_ptr ^ 8'ha5), .i_status(status), .i_ext_clk_cmd(ext_cmd), .o_wr_stb(wr_stb),
		.o_wr_is_data(wr_is_data), .o_wr_byte(wr_byte), .o_ram_rd_stb(ram_rd_stb), .o_mode(dev_mode),
		.o_ext_clk_sel(ext_sel));
	lhi_bus_chk lhi_bus_chk_i (.i_mclk(mclk), .i_lclk(lclk), .i_reset_n(rst_n), .res_n(lhi_bus_if_i.res_n),
		.protocol_strap_a(lhi_bus_if_i.protocol_strap_a), .protocol_strap_b(lhi_bus_if_i.protocol_strap_b),
		.cs_n(lhi_bus_if_i.cs_n), .dc(lhi_bus_if_i.dc), .rw_wr_n(lhi_bus_if_i.rw_wr_n),
		.e_rd_n(lhi_bus_if_i.e_rd_n), .h_d(lhi_bus_if_i.h_d), .h_d_oe(lhi_bus_if_i.h_d_oe),
		.p_d_oe(lhi_bus_if_i.p_d_oe));

	// ****************************************************************
	// Clocks, display memory stand-in, result watchers
	// ****************************************************************
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		lclk = 1'b0;
		#7;
		forever #15 lclk = ~lclk;
	end
	initial ram_ptr = 8'h00;
	always @(posedge lclk) begin
		if (ram_rd_stb === 1'b1)
			ram_ptr <= ram_ptr + 8'h01;
	end
	// Sampled on the falling edge so registered pulses have settled
	always @(negedge lclk) begin
		if (wr_stb === 1'b1)
			chk({wr_is_data, wr_byte}, wq.size() ? wq.pop_front() : 9'hxxx);
	end
	always @(negedge mclk) begin
		if (rd_valid === 1'b1)
			chk({1'b0, rd_byte}, rq.size() ? rq.pop_front() : 9'hxxx);
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errors++;
			stop_test();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_idle();
		for (int n = 0; n < 4000 && busy !== 1'b0; n++)
			@(negedge mclk);
		@(negedge mclk);
	endtask
	task automatic xfer(input logic rd, input logic dcv, input logic [7:0] b);
		@(negedge mclk);
		req = 1'b1;
		req_read = rd;
		req_dc = dcv;
		req_byte = b;
		@(negedge mclk);
		req = 1'b0;
		wait_idle();
	endtask
	task automatic wr(input logic dcv, input logic [7:0] b);
		wq.push_back({dcv, b});
		xfer(1'b0, dcv, b);
	endtask
	// Display reads return the byte latched by the previous display read
	task automatic rdd(input logic dcv);
		if (dcv) begin
			rq.push_back({1'b0, latch});
			latch = nrd ^ 8'ha5;
			nrd++;
		end else
			rq.push_back({1'b0, status});
		xfer(1'b1, dcv, 8'h00);
	endtask
	task automatic stop_test();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{req, req_read, req_dc, res_req, ext_cmd} = 5'h00;
		{errors, tests_run, cyc} = {32'h0, 32'h0, 32'h0};
		{req_byte, latch, nrd} = 24'h000000;
		mode = MODE_M68;
		rst_n = 1'b0;
		void'($urandom(32'hdc0a002b));
		status = 8'($urandom);
		repeat (12) @(negedge mclk);
		rst_n = 1'b1;
		repeat (8) @(negedge mclk);
		for (int j = 3; j >= 0; j--) begin
			mode = 2'(j);
			repeat (20) @(negedge mclk);
			chk({7'h00, dev_mode}, {7'h00, 2'(j)});
			repeat (4) wr(1'($urandom), 8'($urandom));
			if (j >= 2) begin
				rdd(1'b1);
				rdd(1'b0);
				rdd(1'b1);
				rdd(1'b1);
			end else begin
				xfer(1'b1, 1'b1, 8'h00);
				chk({8'h00, busy}, 9'h000);
			end
		end
		mode = MODE_I80;
		ext_cmd = 1'b1;
		repeat (20) @(negedge mclk);
		chk({8'h00, ext_sel}, 9'h001);
		res_req = 1'b1;
		@(negedge mclk);
		res_req = 1'b0;
		repeat (600) @(negedge mclk);
		chk({6'h00, dev_mode, ext_sel}, 9'h000);
		wait_idle();
		// A pin reset empties the read pipeline, so the dummy read comes back
		latch = 8'h00;
		rdd(1'b1);
		rdd(1'b1);
		wr(1'($urandom), 8'($urandom));
		repeat (50) @(negedge mclk);
		chk(9'(wq.size() + rq.size()), 9'h000);
		stop_test();
	end
endmodule
